// File: design/ptc_protection_threshold_config.sv
module ptc_protection_threshold_config #(
  parameter int PHASES      = 4,
  parameter int SS_UNIT_CYC = ptc_pkg::SS_UNIT_CYC
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // command port from the bus engine
  input  wire ptc_pkg::ptc_cmd_t    cmd,
  output logic [15:0]               readData,
  output logic                      readValid,
  // pins
  input  wire logic                 enablePin,
  input  wire logic [10:0]          gainStrap,
  // sensed values, core_clk domain
  input  wire logic [PHASES-1:0]    cycleEnd,
  input  wire logic [PHASES*5-1:0]  valleyCurrent,
  input  wire logic [9:0]           fbPermille,
  // converter control
  output logic [PHASES-1:0]         highSideBlock,
  output logic                      converterOn,
  output logic                      softStartActive,
  output logic [9:0]                vrefMv,
  output logic                      analogMode,
  output logic                      telemetryEn,
  output logic                      outputSinkEnable,
  output logic                      multiPhase,
  output logic                      pulseSkipMode,
  output logic [1:0]                freqSel,
  output logic                      overcurrentProtection,
  output logic                      undervoltageProtection,
  // open-drain power good
  output logic                      powerGoodOutput,
  output logic                      powerGoodOe
);
  import ptc_pkg::*;

  // 2-flop sync of pin inputs
  logic        enSync1_r, enSync2_r;
  logic [10:0] gainSync1_r, gainSync2_r;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enSync1_r   <= 1'b0;
      enSync2_r   <= 1'b0;
      gainSync1_r <= 11'h000;
      gainSync2_r <= 11'h000;
    end else begin
      enSync1_r   <= enablePin;
      enSync2_r   <= enSync1_r;
      gainSync1_r <= gainStrap;
      gainSync2_r <= gainSync1_r;
    end
  end

  function automatic logic [31:0] ssCycles(input logic [2:0] sel);
    logic [2:0] s;
    s = (sel > SS_MAX_SEL) ? SS_MAX_SEL : sel;
    ssCycles = 32'(SS_UNIT_CYC) << s; // R17
  endfunction : ssCycles

  // register file
  logic [4:0]  valleyLimit_r, valleyLimit_nxt;
  logic [3:0]  pgThresh_r, pgThresh_nxt;
  logic [3:0]  slewCode_r, slewCode_nxt;
  logic [15:0] vendorCtrl_r, vendorCtrl_nxt;
  logic [3:0]  protSet_r, protSet_nxt;
  logic [2:0]  riseTime_r, riseTime_nxt;
  logic [10:0] scaleLoop_r, scaleLoop_nxt;
  logic [15:0] voutCmd_r, voutCmd_nxt;
  logic [2:0]  lightLoad_r, lightLoad_nxt;
  logic        busConfigured_r, busConfigured_nxt;
  logic        refUpdate_r, refUpdate_nxt;
  logic [15:0] readData_r, readData_nxt;
  logic        readValid_r, readValid_nxt;
  logic        wr;

  always_comb begin
    wr                = cmd.valid & cmd.write;
    valleyLimit_nxt   = valleyLimit_r;
    pgThresh_nxt      = pgThresh_r;
    slewCode_nxt      = slewCode_r;
    vendorCtrl_nxt    = vendorCtrl_r;
    protSet_nxt       = protSet_r;
    riseTime_nxt      = riseTime_r;
    scaleLoop_nxt     = scaleLoop_r;
    voutCmd_nxt       = voutCmd_r;
    lightLoad_nxt     = lightLoad_r;
    busConfigured_nxt = busConfigured_r;
    refUpdate_nxt     = 1'b0;
    readValid_nxt     = cmd.valid & ~cmd.write;
    readData_nxt      = readData_r;
    if (wr) begin
      case (cmd.code)
        CODE_VALLEY_LIMIT: valleyLimit_nxt = cmd.data[4:0]; // R3
        CODE_PG_THRESH:    pgThresh_nxt    = cmd.data[3:0]; // R4 R5
        CODE_SLEW:         slewCode_nxt    = cmd.data[3:0]; // R9
        // factory bits keep their value
        CODE_VENDOR_CTRL:  vendorCtrl_nxt  = (vendorCtrl_r & ~VENDOR_RW_MASK)
                                           | (cmd.data & VENDOR_RW_MASK); // R11 R12 R13
        CODE_PROT_SET:     protSet_nxt     = cmd.data[3:0]; // R20
        CODE_RISE_TIME:    riseTime_nxt    = cmd.data[2:0]; // R17
        CODE_SCALE_LOOP:   scaleLoop_nxt   = cmd.data[10:0]; // R14
        CODE_LIGHT_LOAD:   lightLoad_nxt   = cmd.data[2:0]; // R19
        CODE_VOUT_COMMAND: begin
          voutCmd_nxt       = cmd.data; // R14
          busConfigured_nxt = 1'b1;
          refUpdate_nxt     = 1'b1;
        end
        default: ;
      endcase
    end
    if (cmd.valid & ~cmd.write) begin
      case (cmd.code)
        CODE_VALLEY_LIMIT: readData_nxt = {11'h000, valleyLimit_r};
        CODE_PG_THRESH:    readData_nxt = {12'h000, pgThresh_r};
        CODE_SLEW:         readData_nxt = {12'h000, slewCode_r};
        CODE_VENDOR_CTRL:  readData_nxt = vendorCtrl_r;
        CODE_PROT_SET:     readData_nxt = {12'h000, protSet_r};
        CODE_RISE_TIME:    readData_nxt = {13'h0000, riseTime_r};
        CODE_SCALE_LOOP:   readData_nxt = {5'h00, scaleLoop_r};
        CODE_LIGHT_LOAD:   readData_nxt = {13'h0000, lightLoad_r};
        CODE_VOUT_COMMAND: readData_nxt = voutCmd_r;
        default:           readData_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      valleyLimit_r   <= RST_VALLEY_LIMIT; // R3
      pgThresh_r      <= RST_PG_THRESH;
      slewCode_r      <= RST_SLEW;
      vendorCtrl_r    <= RST_VENDOR_CTRL;
      protSet_r       <= RST_PROT_SET;
      riseTime_r      <= RST_RISE_TIME;
      scaleLoop_r     <= RST_SCALE_LOOP;
      voutCmd_r       <= 16'h0000;
      lightLoad_r     <= RST_LIGHT_LOAD;
      busConfigured_r <= 1'b0;
      refUpdate_r     <= 1'b0;
      readData_r      <= 16'h0000;
      readValid_r     <= 1'b0;
    end else begin
      valleyLimit_r   <= valleyLimit_nxt;
      pgThresh_r      <= pgThresh_nxt;
      slewCode_r      <= slewCode_nxt;
      vendorCtrl_r    <= vendorCtrl_nxt;
      protSet_r       <= protSet_nxt;
      riseTime_r      <= riseTime_nxt;
      scaleLoop_r     <= scaleLoop_nxt;
      voutCmd_r       <= voutCmd_nxt;
      lightLoad_r     <= lightLoad_nxt;
      busConfigured_r <= busConfigured_nxt;
      refUpdate_r     <= refUpdate_nxt;
      readData_r      <= readData_nxt;
      readValid_r     <= readValid_nxt;
    end
  end

  // per-phase consecutive valley over-current counters
  logic [4:0]        ocCount_r [PHASES];
  logic [4:0]        ocCount_nxt [PHASES];
  logic [PHASES-1:0] hsBlock_nxt, hsBlock_r;
  logic              ocTrip;
  always_comb begin
    ocTrip = 1'b0;
    for (int p = 0; p < PHASES; p++) begin
      hsBlock_nxt[p] = valleyCurrent[p*5 +: 5] > valleyLimit_r; // R2
      ocCount_nxt[p] = ocCount_r[p];
      if (cycleEnd[p]) begin
        if (!hsBlock_nxt[p])
          ocCount_nxt[p] = 5'd0; // R22
        else if (ocCount_r[p] != OC_CYCLES)
          ocCount_nxt[p] = ocCount_r[p] + 5'd1;
      end
      if (ocCount_r[p] == OC_CYCLES)
        ocTrip = 1'b1; // R1
    end
  end

  // protection state machine
  ptc_state_t  state_r, state_nxt;
  logic [31:0] timer_r, timer_nxt;
  logic        uvTrip, pgHigh;
  logic        ocFlag_r, ocFlag_nxt, uvFlag_r, uvFlag_nxt;
  logic        pgGood_r, pgGood_nxt;
  always_comb begin
    uvTrip     = fbPermille < PG_LOW_PM[pgThresh_r[3:2]]; // R4 R6
    pgHigh     = fbPermille >= PG_HIGH_PM[pgThresh_r[1:0]]; // R5
    state_nxt  = state_r;
    timer_nxt  = timer_r;
    ocFlag_nxt = ocFlag_r;
    uvFlag_nxt = uvFlag_r;
    pgGood_nxt = pgGood_r;
    case (state_r)
      ST_SOFT: begin
        pgGood_nxt = 1'b0;
        if (!enSync2_r)
          timer_nxt = 32'd0;
        else if (timer_r >= ssCycles(riseTime_r) - 32'd1) begin
          state_nxt = ST_RUN;
          timer_nxt = 32'd0;
        end else
          timer_nxt = timer_r + 32'd1;
      end
      ST_RUN: begin
        if (pgHigh)
          pgGood_nxt = 1'b1;
        if (!enSync2_r)
          state_nxt = ST_SOFT;
        else if (ocTrip || uvTrip) begin
          ocFlag_nxt = ocTrip;
          uvFlag_nxt = uvTrip;
          pgGood_nxt = 1'b0; // R8
          timer_nxt  = 32'd0;
          // undervoltage shares the over-current response
          state_nxt  = protSet_r[OC_RESP_BIT] ? ST_HICCUP : ST_LATCH; // R7 R20
        end
      end
      ST_HICCUP: begin
        pgGood_nxt = 1'b0;
        if (timer_r >= 32'(HICCUP_MULT) * ssCycles(riseTime_r) - 32'd1) begin // R21
          state_nxt  = ST_SOFT;
          timer_nxt  = 32'd0;
          ocFlag_nxt = 1'b0;
          uvFlag_nxt = 1'b0;
        end else
          timer_nxt = timer_r + 32'd1;
      end
      ST_LATCH: begin
        // only a power or enable cycle leaves latch-off
        pgGood_nxt = 1'b0;
        if (!enSync2_r) begin
          state_nxt  = ST_SOFT;
          ocFlag_nxt = 1'b0;
          uvFlag_nxt = 1'b0;
        end
      end
      default: state_nxt = ST_SOFT;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int p = 0; p < PHASES; p++)
        ocCount_r[p] <= 5'd0;
      hsBlock_r <= '0;
      state_r   <= ST_SOFT;
      timer_r   <= 32'd0;
      ocFlag_r  <= 1'b0;
      uvFlag_r  <= 1'b0;
      pgGood_r  <= 1'b0;
    end else begin
      for (int p = 0; p < PHASES; p++)
        ocCount_r[p] <= (state_r == ST_RUN) ? ocCount_nxt[p] : 5'd0;
      hsBlock_r <= hsBlock_nxt;
      state_r   <= state_nxt;
      timer_r   <= timer_nxt;
      ocFlag_r  <= ocFlag_nxt;
      uvFlag_r  <= uvFlag_nxt;
      pgGood_r  <= pgGood_nxt;
    end
  end

  // reference target and slewed reference
  logic [26:0] product;
  logic [9:0]  target, vref_r, vref_nxt, target_r, target_nxt;
  logic [15:0] slewCnt_r, slewCnt_nxt, slewPeriod;
  always_comb begin
    product    = 27'(voutCmd_r) * 27'(scaleLoop_r);
    if ((product >> SCALE_SHIFT) > 27'(REF_MAX_MV))
      target = REF_MAX_MV; // R15
    else if ((product >> SCALE_SHIFT) < 27'(REF_MIN_MV))
      target = REF_MIN_MV; // R15
    else
      target = 10'(product >> SCALE_SHIFT);
    target_nxt = busConfigured_r ? target : REF_DFLT_MV; // R16
    // long counts keep slow slews exact at 5 ns ticks
    slewPeriod  = SLEW_BASE_CYC + 16'(slewCode_r) * SLEW_LSB_CYC; // R9
    vref_nxt    = vref_r;
    slewCnt_nxt = slewCnt_r;
    if (state_r != ST_RUN) begin
      vref_nxt    = target_r; // R10
      slewCnt_nxt = 16'd0;
    end else if (vref_r != target_r) begin
      if (slewCnt_r >= slewPeriod - 16'd1) begin
        slewCnt_nxt = 16'd0;
        if (vref_r + REF_STEP_MV <= target_r && vref_r < target_r)
          vref_nxt = vref_r + REF_STEP_MV;
        else if (vref_r >= target_r + REF_STEP_MV)
          vref_nxt = vref_r - REF_STEP_MV;
        else
          vref_nxt = target_r;
      end else
        slewCnt_nxt = slewCnt_r + 16'd1;
    end else
      slewCnt_nxt = 16'd0;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vref_r    <= REF_DFLT_MV; // R16
      target_r  <= REF_DFLT_MV;
      slewCnt_r <= 16'd0;
    end else begin
      vref_r    <= vref_nxt;
      target_r  <= refUpdate_r | ~busConfigured_r ? target_nxt : target_r; // R14
      slewCnt_r <= slewCnt_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      readData               <= 16'h0000;
      readValid              <= 1'b0;
      highSideBlock          <= '0;
      converterOn            <= 1'b0;
      softStartActive        <= 1'b0;
      vrefMv                 <= REF_DFLT_MV;
      analogMode             <= 1'b1;
      telemetryEn            <= 1'b0;
      outputSinkEnable       <= 1'b1;
      multiPhase             <= 1'b1;
      pulseSkipMode          <= 1'b0;
      freqSel                <= 2'b00;
      overcurrentProtection  <= 1'b0;
      undervoltageProtection <= 1'b0;
      powerGoodOutput        <= 1'b0;
      powerGoodOe            <= 1'b1;
    end else begin
      readData               <= readData_r;
      readValid              <= readValid_r;
      highSideBlock          <= hsBlock_r; // R2
      converterOn            <= enSync2_r & (state_r == ST_SOFT | state_r == ST_RUN);
      softStartActive        <= enSync2_r & (state_r == ST_SOFT);
      vrefMv                 <= vref_r;
      analogMode             <= ~busConfigured_r; // R16
      telemetryEn            <= scaleLoop_r == gainSync2_r; // R18
      outputSinkEnable       <= ~vendorCtrl_r[SINK_DIS_BIT]; // R11
      multiPhase             <= vendorCtrl_r[MULTI_PH_BIT]; // R12
      pulseSkipMode          <= lightLoad_r[0]; // R19
      freqSel                <= lightLoad_r[2:1]; // R19
      overcurrentProtection  <= ocFlag_r;
      undervoltageProtection <= uvFlag_r;
      powerGoodOutput        <= 1'b0;
      powerGoodOe            <= ~pgGood_r; // R8
    end
  end
endmodule : ptc_protection_threshold_config

// File: design/ptc_pkg.sv
// Contract
// R1 - fire over-current protection after 31 consecutive valley over-current cycles
// R2 - valley limit checked per phase on every switching cycle
// R3 - limit field bits 4:0, unsigned, 1.5A per step, resets to 10001
// R4 - power-good low field 3:2 picks 69/74/79/84 percent, reset 00
// R5 - power-good high field 1:0 picks 90/92.5/95/97.5 percent, reset 00
// R6 - under-voltage trips when feedback falls below power-good low level
// R7 - under-voltage trip uses the over-current latch-off or retry response
// R8 - power-good output driven low on any fault
// R9 - slew bits 3:0, 20us/2mV plus 2.5us/2mV per code, reset 0100
// R10 - programmed slew applies only after soft start, not during it
// R11 - control bit 9: 0 enables sink mode, 1 disables, reset 0
// R12 - control bit 3: 0 single-phase, 1 multi-phase, reset 1, alters ramp
// R13 - control bits 15:10, 8:4, 2:0 read-only factory bits
// R14 - host writes scale-loop gain then output voltage; reference recomputed
// R15 - reference clamped to 0.5V through 0.672V
// R16 - without bus setup reference is 0.6V and device runs analog mode
// R17 - soft start 1, 2, 4, 8 or 16 ms via rise-time register
// R18 - output-voltage telemetry only when scale-loop matches real feedback gain
// R19 - forced continuous or pulse-skip light load, four bus-selected frequencies
// R20 - one protection-setting bit picks latch-off or retry for over-current
// R21 - retry waits about five soft-start times before restarting
// R22 - consecutive over-current counter clears on any cycle within the limit
package ptc_pkg;
  // command codes
  localparam logic [7:0] CODE_VOUT_COMMAND  = 8'h21;
  localparam logic [7:0] CODE_SCALE_LOOP    = 8'h29;
  localparam logic [7:0] CODE_RISE_TIME     = 8'h61;
  localparam logic [7:0] CODE_PROT_SET      = 8'hD6;
  localparam logic [7:0] CODE_VALLEY_LIMIT  = 8'hD7;
  localparam logic [7:0] CODE_PG_THRESH     = 8'hD9;
  localparam logic [7:0] CODE_SLEW          = 8'hDA;
  localparam logic [7:0] CODE_LIGHT_LOAD    = 8'hDB;
  localparam logic [7:0] CODE_VENDOR_CTRL   = 8'hEA;
  // reset values
  localparam logic [4:0]  RST_VALLEY_LIMIT  = 5'h11;
  localparam logic [3:0]  RST_PG_THRESH     = 4'h0;
  localparam logic [3:0]  RST_SLEW          = 4'h4;
  localparam logic [15:0] RST_VENDOR_CTRL   = 16'h00E8;
  localparam logic [3:0]  RST_PROT_SET      = 4'h9;
  localparam logic [2:0]  RST_RISE_TIME     = 3'h2;
  localparam logic [10:0] RST_SCALE_LOOP    = 11'h200;
  localparam logic [2:0]  RST_LIGHT_LOAD    = 3'h0;
  // field positions
  localparam int SINK_DIS_BIT  = 9;
  localparam int MULTI_PH_BIT  = 3;
  localparam int OC_RESP_BIT   = 3;
  localparam logic [15:0] VENDOR_RW_MASK = 16'h0208;
  // protection and reference figures, mV and per-mille of reference
  localparam logic [4:0]  OC_CYCLES      = 5'd31;
  localparam logic [9:0]  REF_MIN_MV     = 10'd500;
  localparam logic [9:0]  REF_MAX_MV     = 10'd672;
  localparam logic [9:0]  REF_DFLT_MV    = 10'd600;
  localparam logic [9:0]  REF_STEP_MV    = 10'd2;
  localparam int          SCALE_SHIFT    = 10;
  localparam logic [9:0]  PG_LOW_PM [4]  = '{10'd690, 10'd740, 10'd790, 10'd840};
  localparam logic [9:0]  PG_HIGH_PM [4] = '{10'd900, 10'd925, 10'd950, 10'd975};
  localparam logic [2:0]  HICCUP_MULT    = 3'd5;
  localparam logic [2:0]  SS_MAX_SEL     = 3'd4;
  // slew timing, ns per 2mV step
  localparam int CLK_NS        = 5;
  localparam int SLEW_BASE_NS  = 20000;
  localparam int SLEW_LSB_NS   = 2500;
  localparam logic [15:0] SLEW_BASE_CYC = 16'(SLEW_BASE_NS / CLK_NS);
  localparam logic [15:0] SLEW_LSB_CYC  = 16'(SLEW_LSB_NS / CLK_NS);
  // soft start unit, 1 ms
  localparam int SS_UNIT_NS    = 1000000;
  localparam int SS_UNIT_CYC   = SS_UNIT_NS / CLK_NS;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } ptc_cmd_t;

  typedef enum logic [3:0] {
    ST_SOFT   = 4'b0001,
    ST_RUN    = 4'b0010,
    ST_HICCUP = 4'b0100,
    ST_LATCH  = 4'b1000
  } ptc_state_t;
endpackage : ptc_pkg

// File: tb/ptc_properties.sv
module ptc_properties (
  // clock and reset
  input wire logic              core_clk, rst_n,
  // command port
  input wire ptc_pkg::ptc_cmd_t cmd,
  input wire logic [15:0]       readData,
  input wire logic              readValid,
  // sensed and converter side
  input wire logic [9:0]        fbPermille, vrefMv,
  input wire logic              converterOn, softStartActive, outputSinkEnable, multiPhase,
  input wire logic              overcurrentProtection, undervoltageProtection, powerGoodOutput, powerGoodOe
);
  import ptc_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] pgLow_r, pgLow_nxt;
  logic       run;
  assign run = converterOn && !softStartActive;
  // shadow of the low threshold code, taken from host writes
  always_comb begin
    pgLow_nxt = pgLow_r;
    if (cmd.valid && cmd.write && cmd.code == CODE_PG_THRESH) pgLow_nxt = cmd.data[3:2];
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) pgLow_r <= 2'h0;
    else pgLow_r <= pgLow_nxt;
  end
  a_read_answer: assert property (cmd.valid && !cmd.write |-> ##2 readValid) else $error("read not answered");
  a_no_stray: assert property (readValid |-> $past(cmd.valid && !cmd.write, 2)) else $error("stray read answer");
  a_factory_bits: assert property (readValid && $past(cmd.code, 2) == CODE_VENDOR_CTRL
    |-> (readData & ~VENDOR_RW_MASK) == 16'h00E0) else $error("factory bits changed");
  a_limit_width: assert property (readValid && $past(cmd.code, 2) == CODE_VALLEY_LIMIT
    |-> readData[15:5] == 11'h000) else $error("limit reserved bits set");
  a_nibble_regs: assert property (readValid && ($past(cmd.code, 2) == CODE_PG_THRESH
    || $past(cmd.code, 2) == CODE_SLEW) |-> readData[15:4] == 12'h000) else $error("reserved bits set");
  a_ctrl_bits: assert property (cmd.valid && cmd.write && cmd.code == CODE_VENDOR_CTRL |-> ##2
    outputSinkEnable == !$past(cmd.data[SINK_DIS_BIT], 2) && multiPhase == $past(cmd.data[MULTI_PH_BIT], 2))
    else $error("control bits wrong");
  a_fault_pg: assert property ($rose(overcurrentProtection || undervoltageProtection)
    |-> ##[0:3] powerGoodOe) else $error("power good kept on fault");
  a_pg_pin: assert property (powerGoodOutput == 1'h0) else $error("power good driven high");
  a_uv_cause: assert property ($rose(undervoltageProtection) |->
    $past(fbPermille, 1) < PG_LOW_PM[pgLow_r] || $past(fbPermille, 2) < PG_LOW_PM[pgLow_r]
    || $past(fbPermille, 3) < PG_LOW_PM[pgLow_r]) else $error("undervoltage without cause");
  a_ref_clamp: assert property (vrefMv >= REF_MIN_MV && vrefMv <= REF_MAX_MV) else $error("reference out of range");
  a_slew_step: assert property (run && $past(run) && $changed(vrefMv) |->
    vrefMv == $past(vrefMv) + REF_STEP_MV || vrefMv + REF_STEP_MV == $past(vrefMv)) else $error("slew step wrong");
  a_slew_gap: assert property (run && $changed(vrefMv) |=> ($stable(vrefMv) || !run) [*8])
    else $error("slew too fast");
endmodule : ptc_properties

bind ptc_protection_threshold_config ptc_properties chk (.core_clk, .rst_n, .cmd, .readData, .readValid,
  .fbPermille, .vrefMv, .converterOn, .softStartActive, .outputSinkEnable, .multiPhase,
  .overcurrentProtection, .undervoltageProtection, .powerGoodOutput, .powerGoodOe);

// File: tb/ptc_host_model.sv
module ptc_host_model (
  // clock
  input  wire logic        core_clk,
  // command side toward the block
  output ptc_pkg::ptc_cmd_t cmd,
  input  wire logic [15:0] readData,
  input  wire logic        readValid
);
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  initial cmd = '0;
  // one command per call; idle fields scrambled so stale code or data is never leaned on
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge core_clk);
    cmd <= '{valid: 1'h1, write: wr, code: code, data: wd};
    @(posedge core_clk);
    cmd <= '{valid: 1'h0, write: ~wr, code: ~code, data: ~wd};
    n = 0;
    while (n < 2 || (!wr && readValid !== 1'h1 && n < 6)) begin
      @(posedge core_clk);
      n++;
    end
    rd = (readValid === 1'h1) ? readData : 16'hXXXX; // missing answer never matches
  endtask : xfer
endmodule : ptc_host_model

// File: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ptc_pkg::*;
  localparam int SS = 20;
  logic             core_clk, rst_n, enablePin, readValid;
  ptc_cmd_t         cmd;
  logic [15:0]      readData;
  logic [10:0]      gainStrap;
  logic [3:0]       cycleEnd, highSideBlock;
  logic [19:0]      valleyCurrent;
  logic [9:0]       fbPermille, vrefMv;
  logic [1:0]       freqSel;
  logic             converterOn, softStartActive, analogMode, telemetryEn, outputSinkEnable, multiPhase;
  logic             pulseSkipMode, overcurrentProtection, undervoltageProtection, powerGoodOutput, powerGoodOe;
  wire              pgLevel = powerGoodOe ? powerGoodOutput : 1'h1; // pulled up when released
  int               error_cnt, check_count, cyc, n;

  ptc_protection_threshold_config #(.PHASES(4), .SS_UNIT_CYC(SS)) dut (.core_clk, .rst_n, .cmd, .readData,
    .readValid, .enablePin, .gainStrap, .cycleEnd, .valleyCurrent, .fbPermille, .highSideBlock, .converterOn,
    .softStartActive, .vrefMv, .analogMode, .telemetryEn, .outputSinkEnable, .multiPhase, .pulseSkipMode,
    .freqSel, .overcurrentProtection, .undervoltageProtection, .powerGoodOutput, .powerGoodOe);
  ptc_host_model host (.core_clk, .cmd, .readData, .readValid);

  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // watchdog, well above the longest sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0000, got}, {15'h0000, exp});
  endtask : chkb
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    host.xfer(1'h1, c, d, r);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] r;
    host.xfer(1'h0, c, 16'h0000, r);
    chk(r, e);
  endtask : rd
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : wait_cyc
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(posedge core_clk);
      k++;
    end
  endtask : wait_lvl
  task automatic wait_ref(input logic [9:0] v, output int k);
    k = 0;
    while (vrefMv !== v && k < 5000) begin
      @(posedge core_clk);
      k++;
    end
  endtask : wait_ref
  task automatic start_run;
    enablePin <= 1'h0;
    wait_cyc(4);
    enablePin <= 1'h1;
    wait_lvl(softStartActive, 1'h1, 20, n);
    wait_lvl(softStartActive, 1'h0, 400, n);
  endtask : start_run
  // k switching cycle ends on phase 0, one every two clocks
  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge core_clk);
      cycleEnd <= 4'h1;
      @(posedge core_clk);
      cycleEnd <= 4'h0;
    end
  endtask : pulses

  task automatic t_reset;
    chk(16'(vrefMv), 16'h0258);
    chkb(analogMode, 1'h1);
    chkb(outputSinkEnable, 1'h1);
    chkb(multiPhase, 1'h1);
    rd(CODE_VALLEY_LIMIT, 16'h0011);
    rd(CODE_PG_THRESH, 16'h0000);
    rd(CODE_SLEW, 16'h0004);
    rd(CODE_VENDOR_CTRL, 16'h00E8);
    rd(8'h55, 16'h0000);
  endtask : t_reset
  task automatic t_regs;
    wr(CODE_VALLEY_LIMIT, 16'hFFFF);
    rd(CODE_VALLEY_LIMIT, 16'h001F);
    wr(CODE_PG_THRESH, 16'hFFFF);
    rd(CODE_PG_THRESH, 16'h000F);
    wr(CODE_SLEW, 16'hFFF0);
    rd(CODE_SLEW, 16'h0000);
    wr(CODE_VENDOR_CTRL, 16'hFFFF);
    rd(CODE_VENDOR_CTRL, 16'h02E8);
    chkb(outputSinkEnable, 1'h0);
    wr(CODE_VENDOR_CTRL, 16'h0000);
    rd(CODE_VENDOR_CTRL, 16'h00E0);
    chkb(multiPhase, 1'h0);
    wr(CODE_VENDOR_CTRL, 16'h0008);
    chkb(multiPhase, 1'h1);
    for (int i = 0; i < 4; i++) begin
      wr(CODE_LIGHT_LOAD, 16'(2 * i + 1));
      chk(16'(freqSel), 16'(i));
      chkb(pulseSkipMode, 1'h1);
    end
    wr(CODE_LIGHT_LOAD, 16'h0000);
    chkb(pulseSkipMode, 1'h0);
  endtask : t_regs
  // outside run the reference jumps straight to the clamped target
  task automatic t_vref;
    wr(CODE_SCALE_LOOP, 16'h0200);
    wr(CODE_VOUT_COMMAND, 16'h07D0);
    // reference passes a target stage and a vref stage too, so it lands two cycles after other fields
    wait_cyc(2);
    chk(16'(vrefMv), 16'h02A0);
    chkb(analogMode, 1'h0);
    wr(CODE_VOUT_COMMAND, 16'h0320);
    wait_cyc(2);
    chk(16'(vrefMv), 16'h01F4);
    wr(CODE_VOUT_COMMAND, 16'h04B0);
    wait_cyc(2);
    chk(16'(vrefMv), 16'h0258);
    chkb(telemetryEn, 1'h0);
    gainStrap <= 11'h200;
    wait_cyc(6);
    chkb(telemetryEn, 1'h1);
  endtask : t_vref
  task automatic t_ss;
    for (int s = 0; s < 5; s++) begin
      enablePin <= 1'h0;
      wr(CODE_RISE_TIME, 16'(s));
      wait_cyc(3);
      enablePin <= 1'h1;
      wait_lvl(softStartActive, 1'h1, 20, n);
      wait_lvl(softStartActive, 1'h0, 400, n);
      chkb(n >= (SS << s) - 2 && n <= (SS << s) + 2, 1'h1);
    end
  endtask : t_ss
  // good only after soft start ends: once released it holds until a fault or an enable drop
  task automatic t_pg;
    fbPermille <= 10'h3CE;
    start_run();
    wait_cyc(6);
    chkb(pgLevel, 1'h0);
    fbPermille <= 10'h3CF;
    wait_cyc(6);
    chkb(pgLevel, 1'h1);
  endtask : t_pg
  task automatic t_slew;
    wr(CODE_VOUT_COMMAND, 16'h04B8);
    wait_ref(10'h25A, n);
    wait_ref(10'h25C, n);
    chkb(n >= SLEW_BASE_CYC - 2 && n <= SLEW_BASE_CYC + 2, 1'h1);
    wait_cyc(20);
    chk(16'(vrefMv), 16'h025C);
  endtask : t_slew
  task automatic t_oc;
    wr(CODE_PROT_SET, 16'h0001);
    wr(CODE_VALLEY_LIMIT, 16'h0005);
    valleyCurrent <= {5'h00, 5'h00, 5'h05, 5'h06};
    wait_cyc(3);
    chk(16'(highSideBlock), 16'h0001);
    pulses(30);
    valleyCurrent <= {5'h00, 5'h00, 5'h05, 5'h05};
    pulses(1);
    valleyCurrent <= {5'h00, 5'h00, 5'h05, 5'h06};
    pulses(30);
    wait_cyc(4);
    chkb(overcurrentProtection, 1'h0);
    pulses(1);
    wait_cyc(4);
    chkb(overcurrentProtection, 1'h1);
    chkb(pgLevel, 1'h0);
    wait_cyc(500);
    chkb(converterOn, 1'h0);
    valleyCurrent <= 20'h00000;
  endtask : t_oc
  task automatic t_uv;
    wr(CODE_PROT_SET, 16'h0009);
    wr(CODE_PG_THRESH, 16'h0004);
    wr(CODE_RISE_TIME, 16'h0002);
    start_run();
    fbPermille <= 10'h2E4;
    wait_cyc(6);
    chkb(undervoltageProtection, 1'h0);
    fbPermille <= 10'h2E3;
    wait_lvl(undervoltageProtection, 1'h1, 8, n);
    chkb(undervoltageProtection, 1'h1);
    fbPermille <= 10'h3E8;
    wait_cyc(2);
    chkb(converterOn, 1'h0);
    chkb(pgLevel, 1'h0);
    wait_lvl(softStartActive, 1'h1, 500, n);
    chkb(n >= 5 * (SS << 2) - 8 && n <= 5 * (SS << 2) + 8, 1'h1);
    chkb(undervoltageProtection, 1'h0);
  endtask : t_uv

  initial begin
    rst_n = 1'h0;
    enablePin = 1'h0;
    gainStrap = 11'h1F4;
    cycleEnd = 4'h0;
    valleyCurrent = 20'h00000;
    fbPermille = 10'h3E8;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    wait_cyc(6);
    rst_n <= 1'h1;
    @(posedge core_clk);
    t_reset();
    t_regs();
    t_vref();
    t_ss();
    t_pg();
    t_slew();
    t_oc();
    t_uv();
    complete_run();
  end
endmodule : testbench
